// file: rtl/rfd_consts.svh
// Offsets, field positions, reset values and field codes of the receive decoder config bank
`ifndef RFD_CONSTS_SVH
`define RFD_CONSTS_SVH
`define RFD_IDX_SOF_WIDTH   8'h16
`define RFD_IDX_PRESET_A    8'h17
`define RFD_IDX_RX_CTRL1    8'h19
`define RFD_IDX_DEC_SETUP   8'h1a
`define RFD_IDX_PHASE       8'h1b
`define RFD_IDX_LEVELS      8'h1c
`define RFD_IDX_PRESET_B    8'h1d
`define RFD_IDX_GUARD       8'h21
`define RFD_IDX_RX_STATUS   8'h30
`define RFD_RST_SOF_WIDTH   8'h3f
`define RFD_RST_PRESET      8'h00
`define RFD_RST_RX_CTRL1    8'h8b
`define RFD_RST_DEC_SETUP   8'h00
`define RFD_RST_PHASE       8'h54
`define RFD_RST_LEVELS      8'h68
`define RFD_RST_GUARD       8'h08
`define RFD_SPC_8           3'h3
`define RFD_SPC_16          3'h4
`define RFD_FRAME_LEGACY    2'h0
`define RFD_FRAME_ISO       2'h2
`define RFD_BIT_MULTI       6
`define RFD_BIT_COLLMASK    5
`define RFD_BIT_POLARITY    2
`endif

// file: rtl/rfd_pkg.sv
// Types shared by the receive decoder config bank
package rfd_pkg;
	typedef enum logic [1:0] {RFD_RX_IDLE, RFD_RX_GUARD, RFD_RX_ACTIVE, RFD_RX_OFF} rfd_rx_state_t;
endpackage : rfd_pkg

// file: rtl/rfd_config.sv
// APB register bank and receive control for the vicinity-card decoder path
`timescale 1ns/1ps
`include "rfd_consts.svh"
// Function
// [RQ1] SOF pulse lasts 2*(width+1) oscillator clocks, full 8-bit field.
// [RQ2] Software programs SOF width 0x3F or 0x73 per mode.
// [RQ3] Software leaves reserved presets 0x17 and 0x1D at zero.
// [RQ4] Pulse count code 011 selects 8, 100 selects 16; others reserved.
// [RQ5] Software keeps receiver control bits 4..2 at 010.
// [RQ6] Gain code selects 27, 31, 38 or 42 dB step.
// [RQ7] Multi-frame off: receiver stops after one stream; on: keeps receiving.
// [RQ8] Collision masking forces bits after a collision to zero.
// [RQ9] Frame type 00 legacy, 10 ISO; 01 and 11 reserved.
// [RQ10] Polarity 0: first-half modulation is 1; polarity 1: it is 0.
// [RQ11] Phase offset field drives clock phase; resets to 0x54.
// [RQ12] Inputs weaker than minimum level are ignored.
// [RQ13] Collision flagged only when weaker half reaches collision level.
// [RQ14] Software keeps decode setup bits 7 and 1..0 at zero.
// [RQ15] After transmit, receiver waits guard bit clocks, ignoring input.
// [RQ16] Every register loads its reset value on reset.
module rfd_config
	import rfd_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sof_start,
	output logic             sof_mod_out,
	input  wire logic        tx_done,
	input  wire logic        bit_tick,
	input  wire logic        half_valid,
	input  wire logic [3:0]  half1_amp,
	input  wire logic [3:0]  half2_amp,
	input  wire logic        frame_end,
	output logic             rx_enable,
	output logic             bit_valid,
	output logic             bit_data,
	output logic             bit_collision,
	output logic [4:0]       pulses_per_bit,
	output logic             pulse_code_bad,
	output logic [5:0]       gain_db,
	output logic             frame_iso,
	output logic             frame_code_bad,
	output logic [7:0]       tx_rx_phase_offset
);
	logic [7:0]    sof_pulse_width_reg;
	logic [7:0]    receiver_control_one_reg;
	logic [7:0]    frame_decode_setup_reg;
	logic [7:0]    tx_rx_phase_offset_reg;
	logic [7:0]    decode_levels_reg;
	logic [7:0]    receive_guard_delay_reg;
	logic [7:0]    preset_a_reg;
	logic [7:0]    preset_b_reg;
	logic [9:0]    sof_cnt_reg;
	logic [7:0]    guard_cnt_reg;
	logic          coll_seen_reg;
	rfd_rx_state_t rx_state_reg;
	logic          bit_valid_reg;
	logic          bit_data_reg;
	logic          bit_coll_reg;
	logic          wr_en;
	logic          wr_hit;
	logic          rd_en;
	logic [9:0]    word_idx;
	logic          idx_hit;
	logic [7:0]    rd_val;
	logic [3:0]    strong_amp;
	logic [3:0]    weak_amp;
	logic          strong_ok;
	logic          coll_now;
	logic          first_half_mod;
	logic          raw_bit;
	logic          bit_take;

	// No wait states; index is the printed offset, byte address is four times it
	assign pready   = 1'b1;
	assign wr_en    = psel && penable && pwrite;
	assign wr_hit   = wr_en && idx_hit;
	// Read data is captured in the setup cycle so it already stands at the access edge
	assign rd_en    = psel && !penable && !pwrite;
	assign word_idx = paddr[11:2];
	assign idx_hit  = (paddr[1:0] == 2'h0) && (word_idx[9:8] == 2'h0);

	// Read decode; unmapped words read zero and raise pslverr
	always_comb begin
		rd_val  = 8'h00;
		pslverr = 1'b0;
		if (!idx_hit) begin
			pslverr = psel && penable;
		end else begin
			unique case (word_idx[7:0])
				`RFD_IDX_SOF_WIDTH: rd_val = sof_pulse_width_reg;
				`RFD_IDX_PRESET_A:  rd_val = preset_a_reg;
				`RFD_IDX_RX_CTRL1:  rd_val = receiver_control_one_reg;
				`RFD_IDX_DEC_SETUP: rd_val = frame_decode_setup_reg;
				`RFD_IDX_PHASE:     rd_val = tx_rx_phase_offset_reg;
				`RFD_IDX_LEVELS:    rd_val = decode_levels_reg;
				`RFD_IDX_PRESET_B:  rd_val = preset_b_reg;
				`RFD_IDX_GUARD:     rd_val = receive_guard_delay_reg;
				`RFD_IDX_RX_STATUS: rd_val = {4'h0, coll_seen_reg, rx_enable, rx_state_reg};
				default:            pslverr = psel && penable;
			endcase
		end
	end

	// Read data registered at the setup edge; status is therefore one cycle old
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0;
		end else if (rd_en) begin
			prdata <= {24'h0, rd_val};
		end
	end

	// SOF width; every write takes the low byte of pwdata
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sof_pulse_width_reg <= `RFD_RST_SOF_WIDTH; // RQ16
		end else if (wr_hit && (word_idx[7:0] == `RFD_IDX_SOF_WIDTH)) begin
			sof_pulse_width_reg <= pwdata[7:0]; // RQ1
		end
	end

	// Receiver control: pulse count and gain; bits 4..2 are kept as written
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			receiver_control_one_reg <= `RFD_RST_RX_CTRL1; // RQ16
		end else if (wr_hit && (word_idx[7:0] == `RFD_IDX_RX_CTRL1)) begin
			receiver_control_one_reg <= pwdata[7:0];
		end
	end

	// Decode setup: multi-frame, masking, framing and polarity
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			frame_decode_setup_reg <= `RFD_RST_DEC_SETUP; // RQ16
		end else if (wr_hit && (word_idx[7:0] == `RFD_IDX_DEC_SETUP)) begin
			frame_decode_setup_reg <= pwdata[7:0];
		end
	end

	// Phase offset; a wrong value breaks reception, so reset loads a working default
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_rx_phase_offset_reg <= `RFD_RST_PHASE; // RQ11
		end else if (wr_hit && (word_idx[7:0] == `RFD_IDX_PHASE)) begin
			tx_rx_phase_offset_reg <= pwdata[7:0];
		end
	end

	// Minimum level in the upper nibble, collision level in the lower
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			decode_levels_reg <= `RFD_RST_LEVELS; // RQ16
		end else if (wr_hit && (word_idx[7:0] == `RFD_IDX_LEVELS)) begin
			decode_levels_reg <= pwdata[7:0];
		end
	end

	// Guard delay in bit clocks after a transmission
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			receive_guard_delay_reg <= `RFD_RST_GUARD; // RQ16
		end else if (wr_hit && (word_idx[7:0] == `RFD_IDX_GUARD)) begin
			receive_guard_delay_reg <= pwdata[7:0]; // RQ15
		end
	end

	// Reserved preset; stays writable so a stray write is visible on read back
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			preset_a_reg <= `RFD_RST_PRESET; // RQ16
		end else if (wr_hit && (word_idx[7:0] == `RFD_IDX_PRESET_A)) begin
			preset_a_reg <= pwdata[7:0];
		end
	end

	// Second reserved preset, same handling as the first
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			preset_b_reg <= `RFD_RST_PRESET; // RQ16
		end else if (wr_hit && (word_idx[7:0] == `RFD_IDX_PRESET_B)) begin
			preset_b_reg <= pwdata[7:0];
		end
	end

	// SOF pulse counter: loads 2*(w+1) clocks; ten bits, since 0xff asks for 512
	// A start while the pulse runs reloads it, so the pulse is stretched, not doubled
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sof_cnt_reg <= 10'h0;
		end else if (sof_start) begin
			sof_cnt_reg <= {1'b0, sof_pulse_width_reg, 1'b0} + 10'h2; // RQ1
		end else if (sof_cnt_reg != 10'h0) begin
			sof_cnt_reg <= sof_cnt_reg - 10'h1;
		end
	end
	assign sof_mod_out = (sof_cnt_reg != 10'h0); // RQ1

	// Static decodes of the receiver control fields
	always_comb begin
		pulse_code_bad = 1'b0;
		unique case (receiver_control_one_reg[7:5])
			`RFD_SPC_8:  pulses_per_bit = 5'h08; // RQ4
			`RFD_SPC_16: pulses_per_bit = 5'h10; // RQ4
			default: begin
				pulses_per_bit = 5'h00;
				pulse_code_bad = 1'b1;
			end
		endcase
	end

	// Gain step in dB; all four codes are defined
	always_comb begin
		unique case (receiver_control_one_reg[1:0])
			2'h0: gain_db = 6'h1b; // RQ6
			2'h1: gain_db = 6'h1f;
			2'h2: gain_db = 6'h26;
			2'h3: gain_db = 6'h2a;
		endcase
	end

	assign frame_iso          = (frame_decode_setup_reg[4:3] == `RFD_FRAME_ISO); // RQ9
	assign frame_code_bad     = !frame_iso && (frame_decode_setup_reg[4:3] != `RFD_FRAME_LEGACY); // RQ9
	assign tx_rx_phase_offset = tx_rx_phase_offset_reg; // RQ11

	// Receive sequencing: guard after transmit, then active until a frame ends with multi-frame off
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_state_reg <= RFD_RX_IDLE;
		end else if (tx_done) begin
			rx_state_reg <= (receive_guard_delay_reg == 8'h0) ? RFD_RX_ACTIVE : RFD_RX_GUARD;
		end else begin
			unique case (rx_state_reg)
				RFD_RX_IDLE, RFD_RX_OFF: ;
				RFD_RX_GUARD: if (bit_tick && (guard_cnt_reg == 8'h1)) begin
					rx_state_reg <= RFD_RX_ACTIVE; // RQ15
				end
				RFD_RX_ACTIVE: if (frame_end && !frame_decode_setup_reg[`RFD_BIT_MULTI]) begin
					rx_state_reg <= RFD_RX_OFF; // RQ7
				end
			endcase
		end
	end

	// Guard counter counts bit clocks only while guarding; input is ignored meanwhile
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			guard_cnt_reg <= 8'h0;
		end else if (tx_done) begin
			guard_cnt_reg <= receive_guard_delay_reg; // RQ15
		end else if ((rx_state_reg == RFD_RX_GUARD) && bit_tick) begin
			guard_cnt_reg <= guard_cnt_reg - 8'h1;
		end
	end
	assign rx_enable = (rx_state_reg == RFD_RX_ACTIVE);

	// Half-bit evaluation against the two thresholds
	assign strong_amp     = (half1_amp >= half2_amp) ? half1_amp : half2_amp;
	assign weak_amp       = (half1_amp >= half2_amp) ? half2_amp : half1_amp;
	assign strong_ok      = strong_amp >= decode_levels_reg[7:4]; // RQ12
	assign coll_now       = weak_amp >= decode_levels_reg[3:0]; // RQ13
	assign first_half_mod = half1_amp > half2_amp;
	assign raw_bit        = first_half_mod ^ frame_decode_setup_reg[`RFD_BIT_POLARITY]; // RQ10

	// Half-bit pairs are taken only while active and strong enough
	assign bit_take = rx_enable && half_valid && strong_ok; // RQ12

	// Valid strobe stands one cycle per accepted half-bit pair
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bit_valid_reg <= 1'b0;
		end else begin
			bit_valid_reg <= bit_take; // RQ12
		end
	end

	// Collision flag of the bit just taken
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bit_coll_reg <= 1'b0;
		end else if (bit_take) begin
			bit_coll_reg <= coll_now; // RQ13
		end
	end

	// Data bit; the colliding bit itself passes, only later bits are masked
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bit_data_reg <= 1'b0;
		end else if (bit_take) begin
			bit_data_reg <= (frame_decode_setup_reg[`RFD_BIT_COLLMASK] && coll_seen_reg)
				? 1'b0 : raw_bit; // RQ8
		end
	end

	// Collision memory; a collision in the closing cycle wins over the clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			coll_seen_reg <= 1'b0;
		end else if (bit_take && coll_now) begin
			coll_seen_reg <= 1'b1; // RQ8
		end else if (frame_end || tx_done) begin
			coll_seen_reg <= 1'b0;
		end
	end
	assign bit_valid     = bit_valid_reg;
	assign bit_data      = bit_data_reg;
	assign bit_collision = bit_coll_reg;
endmodule : rfd_config

// file: testbench/rfd_checker.sv
// Port-level assertions for the receive decoder config bank
`timescale 1ns/1ps
module rfd_checker (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        sof_start,
	input wire logic        sof_mod_out,
	input wire logic        tx_done,
	input wire logic        bit_tick,
	input wire logic        half_valid,
	input wire logic        frame_end,
	input wire logic        rx_enable,
	input wire logic        bit_valid,
	input wire logic        bit_collision,
	input wire logic [4:0]  pulses_per_bit,
	input wire logic        pulse_code_bad,
	input wire logic [5:0]  gain_db,
	input wire logic        frame_iso,
	input wire logic        frame_code_bad,
	input wire logic [7:0]  tx_rx_phase_offset
);
	// One clock domain, so clock and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Shortest legal pulse is two cycles, for a width field of zero
	property p_sof; sof_start |=> sof_mod_out [*2]; endproperty
	a_sof: assert property (p_sof) else $error("sof pulse too short");
	property p_sof_src; $rose(sof_mod_out) |-> $past(sof_start); endproperty
	a_sof_src: assert property (p_sof_src) else $error("sof pulse without start");
	property p_ppb; pulses_per_bit inside {5'h0, 5'h8, 5'h10} && pulse_code_bad == (pulses_per_bit == 5'h0); endproperty
	a_ppb: assert property (p_ppb) else $error("pulse count decode wrong");
	property p_gain; gain_db inside {6'h1b, 6'h1f, 6'h26, 6'h2a}; endproperty
	a_gain: assert property (p_gain) else $error("gain step out of table");
	property p_frame; frame_code_bad |-> !frame_iso; endproperty
	a_frame: assert property (p_frame) else $error("reserved framing taken as iso");
	property p_bit; bit_valid |-> $past(half_valid && rx_enable); endproperty
	a_bit: assert property (p_bit) else $error("bit without active half-bit");
	property p_off; $fell(rx_enable) |-> $past(frame_end || tx_done); endproperty
	a_off: assert property (p_off) else $error("receiver dropped without cause");
	property p_on; $rose(rx_enable) |-> $past(bit_tick || tx_done); endproperty
	a_on: assert property (p_on) else $error("receiver woke without guard end");
	property p_phase; $changed(tx_rx_phase_offset) |-> $past(psel && penable && pwrite); endproperty
	a_phase: assert property (p_phase) else $error("phase changed without write");
	// Second cycle of reset, so the asynchronous clear has surely landed
	property p_rst; disable iff (1'b0) !nrst && $past(!nrst) |-> !rx_enable && !sof_mod_out; endproperty
	a_rst: assert property (p_rst) else $error("outputs busy in reset");
	c_coll: cover property (bit_valid && bit_collision);
	c_off: cover property ($fell(rx_enable));
	c_sof: cover property (sof_start ##1 sof_mod_out);
endmodule : rfd_checker
bind rfd_config rfd_checker u_rfd_checker (.*);

// file: testbench/rfd_label.sv
// Behavioural label in the field, handing half-bit amplitudes to the decoder
`timescale 1ns/1ps
module rfd_label (
	input  wire logic       clk,
	output logic            half_valid,
	output logic      [3:0] half1_amp,
	output logic      [3:0] half2_amp,
	output logic            frame_end
);
	initial begin
		half_valid = 1'b0;
		frame_end = 1'b0;
		half1_amp = 4'h5;
		half2_amp = 4'ha;
	end
	// Amplitudes flip after each half-bit so stale values never look valid
	task half(input logic [3:0] a, input logic [3:0] b);
		@(posedge clk);
		half_valid <= 1'b1;
		half1_amp <= a;
		half2_amp <= b;
		@(posedge clk);
		half_valid <= 1'b0;
		half1_amp <= ~a;
		half2_amp <= ~b;
	endtask : half
	task eof();
		@(posedge clk);
		frame_end <= 1'b1;
		@(posedge clk);
		frame_end <= 1'b0;
	endtask : eof
endmodule : rfd_label

// file: testbench/rf_receive_decoder_config_tb.sv
// Self-checking bench for the receive decoder config bank
`timescale 1ns/1ps
module rf_receive_decoder_config_tb;
	logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [2:0]  strb = 3'h0;
	logic        pready, pslverr, sof_mod_out, rx_enable, bit_valid, bit_data, bit_collision;
	logic        pulse_code_bad, frame_iso, frame_code_bad, half_valid, frame_end, err_s;
	logic [4:0]  pulses_per_bit;
	logic [5:0]  gain_db;
	logic [7:0]  tx_rx_phase_offset;
	logic [3:0]  half1_amp, half2_amp;
	int          error_cnt = 0, comparisons = 0;
	always #5 clk = ~clk;
	rfd_config u_rfd_config (.*, .sof_start(strb[0]), .tx_done(strb[1]), .bit_tick(strb[2]));
	rfd_label u_rfd_label (.*);
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task wrap_up();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : wrap_up
	// Read data stands from the setup edge on, so it is taken at the completing edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		err_s = pslverr;
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
		if (n >= 20) begin
			error_cnt++;
			wrap_up();
		end
	endtask : apb
	task pulse(input int i);
		@(posedge clk);
		strb[i] <= 1'b1;
		@(posedge clk);
		strb <= 3'h0;
	endtask : pulse
	task lbit(input logic [3:0] a, input logic [3:0] b, input logic v, input logic d, input logic c);
		u_rfd_label.half(a, b);
		#1;
		chk("bit valid", 32'(bit_valid), 32'(v));
		if (v) begin
			chk("bit data", 32'(bit_data), 32'(d));
			chk("collision", 32'(bit_collision), 32'(c));
		end
	endtask : lbit
	task s_reset();
		logic [11:0] ad [8] = '{12'h58, 12'h5c, 12'h64, 12'h68, 12'h6c, 12'h70, 12'h74, 12'h84};
		logic [7:0]  rv [8] = '{8'h3f, 8'h00, 8'h8b, 8'h00, 8'h54, 8'h68, 8'h00, 8'h08};
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, ad[i], 32'h0);
			chk("reset value", q, {24'h0, rv[i]});
		end
		chk("phase", 32'(tx_rx_phase_offset), 32'h54);
		chk("pulses", 32'(pulses_per_bit), 32'h10);
		apb(1'b0, 12'h5c, 32'h0);
		chk("preset a", q, 32'h0);
		apb(1'b0, 12'h74, 32'h0);
		chk("preset b", q, 32'h0);
	endtask : s_reset
	task s_regs();
		logic [31:0] gdb [4] = '{32'h1b, 32'h1f, 32'h26, 32'h2a};
		for (int g = 0; g < 4; g++) begin
			apb(1'b1, 12'h64, {24'h0, 6'h1a, g[1:0]});
			chk("gain", 32'(gain_db), gdb[g]);
			chk("pulses", 32'(pulses_per_bit), 32'h8);
			chk("pulse code bad", 32'(pulse_code_bad), 32'h0);
		end
		apb(1'b1, 12'h64, 32'h8a);
		chk("pulses", 32'(pulses_per_bit), 32'h10);
		apb(1'b1, 12'h64, 32'h0a);
		chk("pulse code bad", 32'(pulse_code_bad), 32'h1);
		for (int f = 0; f < 4; f++) begin
			apb(1'b1, 12'h68, {27'h0, f[1:0], 3'h0});
			chk("iso", 32'(frame_iso), 32'(f == 2));
			chk("frame bad", 32'(frame_code_bad), 32'(f[0]));
		end
		apb(1'b1, 12'h6c, 32'h12);
		chk("phase", 32'(tx_rx_phase_offset), 32'h12);
		apb(1'b1, 12'h3fc, 32'h5a);
		chk("slverr", 32'(err_s), 32'h1);
		apb(1'b0, 12'h3fc, 32'h0);
		chk("unmapped", q, 32'h0);
	endtask : s_regs
	// Fast and standard widths; pulse length is 2*(w+1) clocks
	task s_sof();
		int n;
		logic [31:0] w [2] = '{32'h73, 32'h3f};
		logic [31:0] e [2] = '{32'he8, 32'h80};
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, 12'h58, w[k]);
			pulse(0);
			#1 n = 0;
			while (sof_mod_out === 1'b1 && n < 300) begin
				@(posedge clk);
				#1 n++;
			end
			chk("sof width", 32'(n), e[k]);
		end
	endtask : s_sof
	// Guard of two ticks, then a multi-frame pass and a masked single frame
	task s_rx();
		apb(1'b1, 12'h84, 32'h2);
		apb(1'b1, 12'h68, 32'h40);
		pulse(1);
		#1 chk("rx guard", 32'(rx_enable), 32'h0);
		lbit(4'h9, 4'h2, 1'b0, 1'b0, 1'b0);
		pulse(2);
		pulse(2);
		#1 chk("rx on", 32'(rx_enable), 32'h1);
		lbit(4'h9, 4'h2, 1'b1, 1'b1, 1'b0);
		lbit(4'h3, 4'h1, 1'b0, 1'b0, 1'b0);
		u_rfd_label.eof();
		#1 chk("rx multi", 32'(rx_enable), 32'h1);
		apb(1'b1, 12'h68, 32'h24);
		lbit(4'h9, 4'h2, 1'b1, 1'b0, 1'b0);
		lbit(4'h9, 4'h8, 1'b1, 1'b0, 1'b1);
		lbit(4'h2, 4'h9, 1'b1, 1'b0, 1'b0);
		apb(1'b0, 12'hc0, 32'h0);
		chk("status", q, 32'h0e);
		u_rfd_label.eof();
		#1 chk("rx single", 32'(rx_enable), 32'h0);
		lbit(4'h9, 4'h2, 1'b0, 1'b0, 1'b0);
		apb(1'b0, 12'hc0, 32'h0);
		chk("status", q, 32'h03);
	endtask : s_rx
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		s_reset();
		s_regs();
		s_sof();
		s_rx();
		wrap_up();
	end
endmodule : rf_receive_decoder_config_tb
